// ### hdl/vrc_pkg.sv
// Purpose: Constants and types for the voltage reference control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Register offsets are byte addresses
package vrc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] VRC_OFS_FIXED_REF = 12'h000;
    localparam logic [11:0] VRC_OFS_LADDER_CTL = 12'h004;
    localparam logic [11:0] VRC_OFS_LEVEL = 12'h008;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int VRC_FR_ENABLE_BIT = 7;
    localparam int VRC_FR_STABLE_BIT = 6;
    localparam int VRC_FR_GAIN_LSB = 4;
    localparam int VRC_LC_ENABLE_BIT = 7;
    localparam int VRC_LC_LPS_BIT = 6;
    localparam int VRC_LC_PIN_OE_BIT = 5;
    localparam int VRC_LC_POS_LSB = 2;
    localparam int VRC_LC_NEG_BIT = 0;

    // ------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------
    localparam logic [7:0] VRC_FIXED_REF_RESET = 8'h10;
    localparam logic [7:0] VRC_LADDER_CTL_RESET = 8'h00;
    localparam logic [7:0] VRC_LEVEL_RESET = 8'h00;
    localparam logic [7:0] VRC_FIXED_REF_WMASK = 8'hb0;
    localparam logic [7:0] VRC_LADDER_CTL_WMASK = 8'hed;
    localparam logic [7:0] VRC_LEVEL_WMASK = 8'h1f;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int VRC_CLK_MHZ = 100;
    localparam int VRC_SETTLE_US = 25;
    localparam int VRC_SETTLE_CYCLES = VRC_SETTLE_US * VRC_CLK_MHZ;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        VRC_GAIN_RSVD = 2'h0,
        VRC_GAIN_X1 = 2'h1,
        VRC_GAIN_X2 = 2'h2,
        VRC_GAIN_X4 = 2'h3
    } vrc_gain_t;

    typedef enum logic [1:0]
    {
        VRC_POS_SUPPLY = 2'h0,
        VRC_POS_EXT_PIN = 2'h1,
        VRC_POS_FIXED_REF = 2'h2,
        VRC_POS_RSVD = 2'h3
    } vrc_pos_src_t;

    typedef enum logic [1:0]
    {
        VRC_ST_OFF = 2'b00,
        VRC_ST_SETTLING = 2'b01,
        VRC_ST_STABLE = 2'b11
    } vrc_state_t;

endpackage : vrc_pkg

// ### hdl/vrc_settle_timer.sv
// Purpose: Settling timer for the fixed reference
// Assumes: Synchronous active-low reset
// Notes: Stable flag drops at once when enable falls
`timescale 1ns/1ps
`default_nettype none
module vrc_settle_timer
    import vrc_pkg::*;
#(
    parameter int SETTLE_CYCLES = VRC_SETTLE_CYCLES
)
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_enable,
    output logic o_stable
);

    // Elaboration check: count must fit the 16-bit counter
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535)
    begin : g_bad_settle
        $error("SETTLE_CYCLES out of range");
    end

    localparam logic [15:0] LAST = 16'(SETTLE_CYCLES - 1);

    vrc_state_t state;
    vrc_state_t next_state;
    logic [15:0] count;
    logic [15:0] next_count;
    wire logic at_end = (count == LAST);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_count = count;
        case (state)
            VRC_ST_OFF:
            begin
                next_count = 16'h0000;
                if (i_enable)
                    next_state = VRC_ST_SETTLING;
            end
            VRC_ST_SETTLING:
            begin
                next_count = count + 16'h0001;
                if (!i_enable)
                    next_state = VRC_ST_OFF;
                else if (at_end)
                    next_state = VRC_ST_STABLE;
            end
            VRC_ST_STABLE:
            begin
                if (!i_enable)
                    next_state = VRC_ST_OFF;
            end
            default:
            begin
                next_state = VRC_ST_OFF;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            state <= VRC_ST_OFF;
            count <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
        end
    end

    // Flag clears with enable in same cycle
    assign o_stable = (state == VRC_ST_STABLE) && i_enable; // RQ16 RQ9

endmodule : vrc_settle_timer
`default_nettype wire

// ### hdl/vrc_top.sv
// Purpose: Control for a 32-level ladder reference and a fixed reference
// Assumes: APB slave, 100 MHz clock, analog parts outside
// Notes: Level output is the stored code, forced to zero while the ladder is disabled
//
// Notes on behaviour
// RQ1 - Ladder current flows only while ladder enable is one.
// RQ2 - Enabled ladder gives negative plus span times code over 32.
// RQ3 - Disabled ladder outputs positive source if low-power bit set, else negative.
// RQ4 - Ladder reaches the reference pin only while pin output enable is one.
// RQ5 - Routed pin has driver and detector overridden and reads zero.
// RQ6 - Wake from sleep leaves ladder configuration unchanged.
// RQ7 - Reset disables ladder and fixed reference, unroutes pin, clears code.
// RQ8 - Fixed reference enable bit turns the fixed reference on or off.
// RQ9 - Read-only stable flag is one only after the fixed reference settles.
// RQ10 - Gain field: 01 x1, 10 x2, 11 x4, 00 reserved.
// RQ11 - Positive source: 00 supply, 01 external pin, 10 fixed reference.
// RQ12 - Negative source bit: zero ground, one external pin.
// RQ13 - Unimplemented register bits read as zero.
// RQ14 - Firmware waits for settling, may poll the stable flag.
// RQ15 - Firmware should disable the reference before sleep.
// RQ16 - Settling counter starts on enable, flag clears at once on disable.
// RQ17 - Gain resets to x1, all other register bits reset to zero.
`timescale 1ns/1ps
`default_nettype none
module vrc_top
    import vrc_pkg::*;
#(
    parameter int SETTLE_CYCLES = VRC_SETTLE_CYCLES
)
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic i_sleep,
    input wire logic i_pin_digital_in,
    output logic o_ladder_enable,
    output logic [4:0] o_ladder_level_code,
    output logic o_ladder_low_power_state,
    output logic o_ladder_pin_output_enable,
    output logic [1:0] o_ladder_pos_source_select,
    output logic o_ladder_neg_source_select,
    output logic o_ladder_out_positive,
    output logic o_ladder_out_negative,
    output logic o_fixed_ref_enable,
    output logic [1:0] o_fixed_ref_gain_select,
    output logic [2:0] o_fixed_ref_gain_factor,
    output logic o_pin_digital_override,
    output logic o_pin_digital_read
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] fixed_reference_control;
    logic [7:0] ladder_control;
    logic [7:0] ladder_level_select;
    logic [7:0] next_fixed_reference_control;
    logic [7:0] next_ladder_control;
    logic [7:0] next_ladder_level_select;
    logic fixed_ref_stable;
    logic [31:0] next_prdata;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic access = i_psel && i_penable;
    wire logic hit_fr = (i_paddr == VRC_OFS_FIXED_REF);
    wire logic hit_lc = (i_paddr == VRC_OFS_LADDER_CTL);
    wire logic hit_lv = (i_paddr == VRC_OFS_LEVEL);
    wire logic hit_any = hit_fr || hit_lc || hit_lv;
    wire logic wr_lane0 = access && i_pwrite && i_pstrb[0];

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (wd & mask);
    endfunction : merge

    // Reserved bits never stored, so they read zero
    assign next_fixed_reference_control = (wr_lane0 && hit_fr) ?
        merge(fixed_reference_control, i_pwdata[7:0], VRC_FIXED_REF_WMASK) :
        fixed_reference_control; // RQ13 RQ8 RQ10
    assign next_ladder_control = (wr_lane0 && hit_lc) ?
        merge(ladder_control, i_pwdata[7:0], VRC_LADDER_CTL_WMASK) :
        ladder_control; // RQ13
    assign next_ladder_level_select = (wr_lane0 && hit_lv) ?
        merge(ladder_level_select, i_pwdata[7:0], VRC_LEVEL_WMASK) :
        ladder_level_select; // RQ13

    // Stable flag inserted at read time, bit never stored
    wire logic [7:0] fr_read = {fixed_reference_control[7], fixed_ref_stable,
                                fixed_reference_control[5:0]}; // RQ9
    assign next_prdata = !hit_any ? 32'h0000_0000 :
        hit_fr ? {24'h00_0000, fr_read} :
        hit_lc ? {24'h00_0000, ladder_control} :
        {24'h00_0000, ladder_level_select};

    // Sleep and wake are not resets: contents only change on writes
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            fixed_reference_control <= VRC_FIXED_REF_RESET; // RQ7 RQ17
            ladder_control <= VRC_LADDER_CTL_RESET; // RQ7 RQ17
            ladder_level_select <= VRC_LEVEL_RESET; // RQ7 RQ17
            o_prdata <= 32'h0000_0000;
        end
        else
        begin
            fixed_reference_control <= next_fixed_reference_control; // RQ6
            ladder_control <= next_ladder_control; // RQ6
            ladder_level_select <= next_ladder_level_select; // RQ6
            if (i_psel && !i_penable && !i_pwrite)
                o_prdata <= next_prdata;
        end
    end

    // No wait state: read data registered in setup cycle
    assign o_pready = 1'b1;
    assign o_pslverr = access && !hit_any;

    // ------------------------------------------------------------
    // Fixed reference
    // ------------------------------------------------------------
    function automatic logic [2:0] gain_factor(input logic [1:0] sel);
        case (sel)
            VRC_GAIN_X1: gain_factor = 3'h1;
            VRC_GAIN_X2: gain_factor = 3'h2;
            VRC_GAIN_X4: gain_factor = 3'h4;
            default: gain_factor = 3'h0;
        endcase
    endfunction : gain_factor

    assign o_fixed_ref_enable = fixed_reference_control[VRC_FR_ENABLE_BIT]; // RQ8
    assign o_fixed_ref_gain_select = fixed_reference_control[VRC_FR_GAIN_LSB +: 2]; // RQ10
    assign o_fixed_ref_gain_factor = gain_factor(o_fixed_ref_gain_select); // RQ10

    vrc_settle_timer #(
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_settle (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_enable(o_fixed_ref_enable),
        .o_stable(fixed_ref_stable)
    ); // RQ16

    // ------------------------------------------------------------
    // Ladder
    // ------------------------------------------------------------
    assign o_ladder_enable = ladder_control[VRC_LC_ENABLE_BIT]; // RQ1
    assign o_ladder_low_power_state = ladder_control[VRC_LC_LPS_BIT];
    assign o_ladder_pin_output_enable = ladder_control[VRC_LC_PIN_OE_BIT]; // RQ4
    assign o_ladder_pos_source_select = ladder_control[VRC_LC_POS_LSB +: 2]; // RQ11
    assign o_ladder_neg_source_select = ladder_control[VRC_LC_NEG_BIT]; // RQ12
    // Code passes to ladder only while enabled
    assign o_ladder_level_code = o_ladder_enable ? ladder_level_select[4:0] : 5'h00; // RQ2
    assign o_ladder_out_positive = !o_ladder_enable && o_ladder_low_power_state; // RQ3
    assign o_ladder_out_negative = !o_ladder_enable && !o_ladder_low_power_state; // RQ3

    // ------------------------------------------------------------
    // Pin override
    // ------------------------------------------------------------
    assign o_pin_digital_override = o_ladder_pin_output_enable; // RQ5
    assign o_pin_digital_read = o_ladder_pin_output_enable ? 1'b0 : i_pin_digital_in; // RQ5

    wire logic unused = i_sleep ^ (|i_pwdata[31:8]) ^ (|i_pstrb[3:1]);

endmodule : vrc_top
`default_nettype wire

// ### bench/vrc_top_sva.sv
// Purpose: Port assertions for vrc_top
// Assumes: One clock, sync active-low reset
// Notes: Bound to every vrc_top
`timescale 1ns/1ps
`default_nettype none
module vrc_top_chk
    import vrc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic i_sleep,
    input wire logic i_pin_digital_in,
    input wire logic o_ladder_enable,
    input wire logic [4:0] o_ladder_level_code,
    input wire logic o_ladder_low_power_state,
    input wire logic o_ladder_pin_output_enable,
    input wire logic o_ladder_out_positive,
    input wire logic o_ladder_out_negative,
    input wire logic o_fixed_ref_enable,
    input wire logic [1:0] o_fixed_ref_gain_select,
    input wire logic [2:0] o_fixed_ref_gain_factor,
    input wire logic o_pin_digital_override,
    input wire logic o_pin_digital_read
);
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);
    logic [7:0] wd_q;
    wire acc = i_psel && i_penable && i_pwrite;
    wire wr_lc = acc && i_pstrb[0] && i_paddr == VRC_OFS_LADDER_CTL;
    always_ff @(posedge i_sys_clk) wd_q <= i_pwdata[7:0];
    chk_level_gate: assert property (!o_ladder_enable |-> o_ladder_level_code == 5'h00)
        else $error("level code while ladder off");
    chk_ctl_write: assert property (wr_lc |=> o_ladder_enable == wd_q[7]
        && o_ladder_pin_output_enable == wd_q[5]) else $error("ladder control write lost");
    chk_out_pos: assert property (o_ladder_out_positive ==
        (!o_ladder_enable && o_ladder_low_power_state)) else $error("positive state wrong");
    chk_out_neg: assert property (o_ladder_out_negative ==
        (!o_ladder_enable && !o_ladder_low_power_state)) else $error("negative state wrong");
    chk_pin_zero: assert property (o_ladder_pin_output_enable |->
        !o_pin_digital_read && o_pin_digital_override) else $error("routed pin not zero");
    chk_pin_pass: assert property (!o_ladder_pin_output_enable |->
        o_pin_digital_read == i_pin_digital_in) else $error("pin read not passed");
    chk_gain_map: assert property (o_fixed_ref_gain_factor == (o_fixed_ref_gain_select == 2'h0
        ? 3'h0 : 3'h1 << (o_fixed_ref_gain_select - 2'h1))) else $error("gain factor wrong");
    chk_reset_clear: assert property ($rose(i_reset_n) |-> !o_ladder_enable
        && !o_fixed_ref_enable && o_fixed_ref_gain_select == 2'h1) else $error("reset state");
    chk_sleep_hold: assert property (i_sleep && !acc |=> $stable(o_ladder_enable)
        && $stable(o_ladder_level_code)) else $error("sleep changed config");
    cover property (wr_lc);
    cover property (o_ladder_pin_output_enable && i_pin_digital_in);
    cover property (i_sleep && o_ladder_pin_output_enable);
    cover property (o_fixed_ref_enable && o_fixed_ref_gain_select == 2'h1);
endmodule : vrc_top_chk
bind vrc_top vrc_top_chk u_chk (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb),
    .i_sleep(i_sleep),
    .i_pin_digital_in(i_pin_digital_in),
    .o_ladder_enable(o_ladder_enable),
    .o_ladder_level_code(o_ladder_level_code),
    .o_ladder_low_power_state(o_ladder_low_power_state),
    .o_ladder_pin_output_enable(o_ladder_pin_output_enable),
    .o_ladder_out_positive(o_ladder_out_positive),
    .o_ladder_out_negative(o_ladder_out_negative),
    .o_fixed_ref_enable(o_fixed_ref_enable),
    .o_fixed_ref_gain_select(o_fixed_ref_gain_select),
    .o_fixed_ref_gain_factor(o_fixed_ref_gain_factor),
    .o_pin_digital_override(o_pin_digital_override),
    .o_pin_digital_read(o_pin_digital_read)
);
`default_nettype wire

// ### bench/vrc_analog_model.sv
// Purpose: Far-side pin and analog stand-in
// Assumes: Pin level is unrelated to the reference
// Notes: Level changes every cycle
`timescale 1ns/1ps
`default_nettype none
module vrc_analog_model (
    input wire logic i_sys_clk,
    output logic o_pin_level
);
    initial o_pin_level = 1'b0;
    always @(posedge i_sys_clk) o_pin_level <= ~o_pin_level;
endmodule : vrc_analog_model
`default_nettype wire

// ### bench/vrc_top_test.sv
// Purpose: Self-checking bench for vrc_top
// Assumes: APB master tasks, short settle count
// Notes: Random register traffic from an LFSR
`timescale 1ns/1ps
`default_nettype none
module vrc_top_test;
    import vrc_pkg::*;
    localparam int SETTLE = 4;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic i_sleep = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0;
    logic [3:0] i_pstrb = 4'hf;
    wire logic i_pin_digital_in, o_pready, o_pslverr, o_ladder_enable, o_ladder_low_power_state;
    wire logic o_ladder_pin_output_enable, o_ladder_neg_source_select, o_ladder_out_positive;
    wire logic o_ladder_out_negative, o_fixed_ref_enable, o_pin_digital_override;
    wire logic o_pin_digital_read;
    wire logic [1:0] o_ladder_pos_source_select, o_fixed_ref_gain_select;
    wire logic [2:0] o_fixed_ref_gain_factor;
    wire logic [4:0] o_ladder_level_code;
    wire logic [31:0] o_prdata;
    int n_fail = 0;
    int check_count = 0;
    logic [31:0] lfsr = 32'h14077946;
    logic [31:0] rd;
    logic err;
    always #5 i_sys_clk = ~i_sys_clk;
    vrc_top #(.SETTLE_CYCLES(SETTLE)) DUT (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_psel(i_psel),
        .i_penable(i_penable),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_pwdata(i_pwdata),
        .i_pstrb(i_pstrb),
        .o_pready(o_pready),
        .o_prdata(o_prdata),
        .o_pslverr(o_pslverr),
        .i_sleep(i_sleep),
        .i_pin_digital_in(i_pin_digital_in),
        .o_ladder_enable(o_ladder_enable),
        .o_ladder_level_code(o_ladder_level_code),
        .o_ladder_low_power_state(o_ladder_low_power_state),
        .o_ladder_pin_output_enable(o_ladder_pin_output_enable),
        .o_ladder_pos_source_select(o_ladder_pos_source_select),
        .o_ladder_neg_source_select(o_ladder_neg_source_select),
        .o_ladder_out_positive(o_ladder_out_positive),
        .o_ladder_out_negative(o_ladder_out_negative),
        .o_fixed_ref_enable(o_fixed_ref_enable),
        .o_fixed_ref_gain_select(o_fixed_ref_gain_select),
        .o_fixed_ref_gain_factor(o_fixed_ref_gain_factor),
        .o_pin_digital_override(o_pin_digital_override),
        .o_pin_digital_read(o_pin_digital_read)
    );
    vrc_analog_model u_far (.i_sys_clk(i_sys_clk), .o_pin_level(i_pin_digital_in));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function logic [31:0] exp_factor(input logic [1:0] g);
        return g == 2'h0 ? 32'h0 : 32'h1 << (g - 2'h1);
    endfunction : exp_factor
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do
            @(posedge i_sys_clk);
        while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_sys_clk);
    endtask : apb
    task conclude;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (20) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        @(posedge i_sys_clk);
        apb(1'b0, VRC_OFS_FIXED_REF, 32'h0);
        check(rd, 32'h10);
        apb(1'b0, VRC_OFS_LADDER_CTL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        check({rd[30:0], err}, 32'h1);
        repeat (40)
        begin
            lfsr = lfsr_next(lfsr);
            apb(1'b1, VRC_OFS_LADDER_CTL, lfsr);
            apb(1'b1, VRC_OFS_LEVEL, lfsr >> 8);
            apb(1'b1, VRC_OFS_FIXED_REF, (lfsr >> 24) & 32'h7f);
            apb(1'b0, VRC_OFS_LADDER_CTL, 32'h0);
            check(rd, lfsr & 32'hed);
            check({24'h0, o_ladder_enable, o_ladder_low_power_state, o_ladder_pin_output_enable, 1'b0,
                o_ladder_pos_source_select, 1'b0, o_ladder_neg_source_select}, lfsr & 32'hed);
            check({30'h0, o_ladder_out_positive, o_ladder_out_negative},
                lfsr[7] ? 32'h0 : (lfsr[6] ? 32'h2 : 32'h1));
            check({30'h0, o_pin_digital_override, o_pin_digital_read},
                lfsr[5] ? 32'h2 : {31'h0, i_pin_digital_in});
            apb(1'b0, VRC_OFS_LEVEL, 32'h0);
            check(rd, (lfsr >> 8) & 32'h1f);
            apb(1'b0, VRC_OFS_FIXED_REF, 32'h0);
            check(rd, (lfsr >> 24) & 32'h30);
            check({27'h0, o_ladder_level_code}, lfsr[7] ? (lfsr >> 8) & 32'h1f : 32'h0);
            check({29'h0, o_fixed_ref_gain_factor}, exp_factor(lfsr[29:28]));
        end
        i_pstrb <= 4'h0;
        apb(1'b1, VRC_OFS_LEVEL, ~(lfsr >> 8));
        i_pstrb <= 4'hf;
        apb(1'b0, VRC_OFS_LEVEL, 32'h0);
        check(rd, (lfsr >> 8) & 32'h1f);
        apb(1'b1, VRC_OFS_FIXED_REF, 32'h90);
        apb(1'b0, VRC_OFS_FIXED_REF, 32'h0);
        check(rd, 32'h90);
        check({31'h0, o_fixed_ref_enable}, 32'h1);
        repeat (SETTLE + 4) @(posedge i_sys_clk);
        apb(1'b0, VRC_OFS_FIXED_REF, 32'h0);
        check(rd, 32'hd0);
        apb(1'b1, VRC_OFS_FIXED_REF, 32'h20);
        apb(1'b0, VRC_OFS_FIXED_REF, 32'h0);
        check(rd, 32'h20);
        apb(1'b1, VRC_OFS_LADDER_CTL, 32'h6d);
        i_sleep <= 1'b1;
        repeat (10) @(posedge i_sys_clk);
        i_sleep <= 1'b0;
        apb(1'b0, VRC_OFS_LADDER_CTL, 32'h0);
        check(rd, 32'h6d);
        apb(1'b1, VRC_OFS_LADDER_CTL, 32'hed);
        apb(1'b1, VRC_OFS_FIXED_REF, 32'ha0);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        @(posedge i_sys_clk);
        apb(1'b0, VRC_OFS_LEVEL, 32'h0);
        check({rd[30:0], o_ladder_pin_output_enable}, 32'h0);
        check({30'h0, o_ladder_enable, o_fixed_ref_enable}, 32'h0);
        apb(1'b0, VRC_OFS_FIXED_REF, 32'h0);
        check(rd, 32'h10);
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge i_sys_clk);
        n_fail++;
        conclude();
    end
endmodule : vrc_top_test
`default_nettype wire
